// >>> verilog/tdc_pkg.sv
// tape dma command and address logic: shared offsets, fields, constants
// assumes one core clock; no timing figures are needed by this block
package tdc_pkg;
    // register word indices on the plain register port
    localparam logic [2:0] ADDR_CS1 = 3'h0;
    localparam logic [2:0] ADDR_WC = 3'h1;
    localparam logic [2:0] ADDR_BA = 3'h2;
    localparam logic [2:0] ADDR_CS3 = 3'h3;
    localparam logic [2:0] ADDR_CTRL = 3'h4;
    // command_and_status_one field positions
    localparam int GO_BIT = 0;
    localparam int FUNC_LSB = 1;
    localparam int FUNC_MSB = 5;
    localparam int IE_BIT = 6;
    localparam int RDY_BIT = 7;
    localparam int EXT_LSB = 8;
    localparam int EXT_MSB = 9;
    localparam int TRE_BIT = 14;
    // command_and_status_three position of the shared enable bit
    localparam int CS3_IE_BIT = 6;
    // control register: bit 0 controller clear, bit 1 double-word mode
    localparam int CTL_CLR_BIT = 0;
    localparam int CTL_DBL_BIT = 1;
    // function codes, go bit included
    localparam logic [5:0] FN_NOP = 6'h01;
    localparam logic [5:0] FN_REWIND_OFF = 6'h03;
    localparam logic [5:0] FN_REWIND = 6'h07;
    // reset values
    localparam logic [15:0] BA_RESET = 16'h0000;
    localparam logic [1:0] EXT_RESET = 2'h0;
    // address steps
    localparam logic [17:0] STEP_SINGLE = 18'h00002;
    localparam logic [17:0] STEP_DOUBLE = 18'h00004;
endpackage : tdc_pkg

// >>> verilog/tdc_addr_step.sv
// tape dma command and address logic: memory address stepper
// assumes an 18-bit address made of the extension bits and the bus address
`timescale 1ns/1ps
module tdc_addr_step (
    input wire logic [17:0] addrIn,
    input wire logic dbl,
    input wire logic reverse,
    output logic [17:0] addrOut
);
    logic [17:0] step;
    always_comb begin
        step = dbl ? tdc_pkg::STEP_DOUBLE : tdc_pkg::STEP_SINGLE;
        // carry out of bit 15 reaches the extension bits naturally
        if (reverse) begin
            addrOut = addrIn - step;
        end else begin
            addrOut = addrIn + step;
        end
        addrOut[0] = 1'b0;
    end
endmodule : tdc_addr_step

// >>> verilog/tdc_cmd_regs.sv
// tape dma command and address logic: registers, command path, transfer
// assumes a plain register port, a drive bus that takes one function write,
// and a memory side that acknowledges each word with wordDone
// Notes on behaviour
// - only a software write may set interrupt enable.
// - with enable set, ready or drive attention raise an interrupt request.
// - enable clears on bus init, controller clear, interrupt acknowledge.
// - writing enable zero cancels a pending interrupt request.
// - writing enable and ready both one makes a software interrupt.
// - enable is also reached through command and status three.
// - function code in bits 5..1, go in bit 0; nop 01, rewinds 03, 07.
// - written function code goes to the selected drive over the drive bus.
// - non-transfer commands do nothing else inside the controller.
// - word counter has no reset; only writes and transfer steps change it.
// - word counter steps by one per word moved.
// - bus address holds bits 15..1; bit 0 reads zero.
// - bus address clears on bus init and controller clear.
// - double-word moves step the address by four.
// - single-word moves step the address by two.
// - ready is one except during transfers; its rise requests an interrupt.
// - extension bits take the carry out of the bus address.
// - while busy only non-transfer commands are accepted.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module tdc_cmd_regs (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic busInit,
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic [2:0] unitSel,
    output logic driveWr,
    output logic [2:0] driveUnit,
    output logic [5:0] driveFunc,
    input wire logic drive_attention,
    output logic intReq,
    input wire logic intAck,
    output logic wordReq,
    input wire logic wordDone,
    input wire logic xferError,
    output logic [17:0] memAddr,
    output logic busy
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_XFER = 2'b10
    } tdc_state_t;

    tdc_state_t state;
    logic interrupt_enable;
    logic intPending;
    logic transfer_error_flag;
    logic [15:0] transfer_word_counter;
    logic [15:1] memory_bus_address;
    logic [1:0] addrExt;
    logic dblMode;
    logic ready;
    logic readyQ;
    logic ctlClear;
    logic wrCs1;
    logic startXfer;
    logic [4:0] wrFunc;
    logic reverseDir;
    logic [17:0] nextAddr;

    function automatic logic isXfer(input logic [4:0] f);
        return f[4] & (f[3] | f[2]);
    endfunction : isXfer

    // reverse transfers are the codes with f4 and f3 both clear of bit 2...
    // here the low two function bits equal 2'b11 mark reverse direction
    function automatic logic isReverse(input logic [4:0] f);
        return f[1] & f[0];
    endfunction : isReverse

    assign ready = (state == ST_IDLE);
    assign busy = ~ready;
    assign ctlClear = regWr && regAddr == tdc_pkg::ADDR_CTRL
        && regWdata[tdc_pkg::CTL_CLR_BIT];
    assign wrCs1 = regWr && regAddr == tdc_pkg::ADDR_CS1;
    assign wrFunc = regWdata[tdc_pkg::FUNC_MSB:tdc_pkg::FUNC_LSB];
    // busy controller ignores new transfer commands
    assign startXfer = wrCs1 && regWdata[tdc_pkg::GO_BIT]
        && isXfer(wrFunc) && ready;
    assign memAddr = {addrExt, memory_bus_address, 1'b0};

    // ------------------------------------------------------------
    // drive bus forwarding
    // ------------------------------------------------------------
    // the code lives in the drive; a copy is held here until the next forwarded write
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            driveWr <= 1'b0;
            driveUnit <= 3'h0;
            driveFunc <= 6'h00;
        end else begin
            // non-transfer codes forward even while busy
            driveWr <= wrCs1 && (ready || !isXfer(wrFunc));
            if (wrCs1 && (ready || !isXfer(wrFunc))) begin
                driveUnit <= unitSel;
                driveFunc <= regWdata[tdc_pkg::FUNC_MSB:0];
            end
        end
    end

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            reverseDir <= 1'b0;
        end else if (busInit || ctlClear) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (startXfer) begin
                        state <= ST_XFER;
                        reverseDir <= isReverse(wrFunc);
                    end
                end
                ST_XFER: begin
                    if (xferError) begin
                        state <= ST_IDLE;
                    end else if (wordDone
                        && transfer_word_counter == 16'hffff) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign wordReq = (state == ST_XFER);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            transfer_error_flag <= 1'b0;
        end else if (busInit || ctlClear || startXfer) begin
            transfer_error_flag <= 1'b0;
        end else if (state == ST_XFER && xferError) begin
            transfer_error_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // word counter: no reset path at all
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (regWr && regAddr == tdc_pkg::ADDR_WC) begin
            transfer_word_counter <= regWdata;
        end else if (state == ST_XFER && wordDone) begin
            transfer_word_counter <= transfer_word_counter
                + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // bus address and extension
    // ------------------------------------------------------------
    tdc_addr_step u_step (
        .addrIn(memAddr),
        .dbl(dblMode),
        .reverse(reverseDir),
        .addrOut(nextAddr)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            memory_bus_address <= tdc_pkg::BA_RESET[15:1];
            addrExt <= tdc_pkg::EXT_RESET;
        end else if (busInit || ctlClear) begin
            memory_bus_address <= tdc_pkg::BA_RESET[15:1];
            addrExt <= tdc_pkg::EXT_RESET;
        end else if (state == ST_XFER && wordDone) begin
            memory_bus_address <= nextAddr[15:1];
            addrExt <= nextAddr[17:16];
        end else if (regWr && regAddr == tdc_pkg::ADDR_BA) begin
            memory_bus_address <= regWdata[15:1];
        end else if (wrCs1 && ready) begin
            addrExt <= regWdata[tdc_pkg::EXT_MSB:tdc_pkg::EXT_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dblMode <= 1'b0;
        end else if (regWr && regAddr == tdc_pkg::ADDR_CTRL) begin
            dblMode <= regWdata[tdc_pkg::CTL_DBL_BIT];
        end
    end

    // ------------------------------------------------------------
    // interrupt enable and request
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_enable <= 1'b0;
        end else if (busInit || ctlClear || intAck) begin
            interrupt_enable <= 1'b0;
        end else if (wrCs1) begin
            interrupt_enable <= regWdata[tdc_pkg::IE_BIT];
        end else if (regWr && regAddr == tdc_pkg::ADDR_CS3) begin
            interrupt_enable <= regWdata[tdc_pkg::CS3_IE_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            readyQ <= 1'b1;
        end else begin
            readyQ <= ready;
        end
    end

    logic ieWrite;
    logic ieWriteVal;
    always_comb begin
        ieWrite = wrCs1 || (regWr && regAddr == tdc_pkg::ADDR_CS3);
        ieWriteVal = wrCs1 ? regWdata[tdc_pkg::IE_BIT]
            : regWdata[tdc_pkg::CS3_IE_BIT];
    end

    // a new event wins over the cancel of the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            intPending <= 1'b0;
        end else if (busInit || ctlClear) begin
            intPending <= 1'b0;
        end else if (wrCs1 && regWdata[tdc_pkg::IE_BIT]
            && regWdata[tdc_pkg::RDY_BIT]) begin
            intPending <= 1'b1;
        end else if (interrupt_enable && ready && !readyQ) begin
            intPending <= 1'b1;
        end else if (intAck || (ieWrite && !ieWriteVal)) begin
            intPending <= 1'b0;
        end
    end

    // attention is a level; it requests while it stands and interrupt enable is set
    assign intReq = intPending
        || (interrupt_enable && drive_attention);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            unique case (regAddr)
                tdc_pkg::ADDR_CS1: regRdata <= {1'b0, transfer_error_flag,
                    4'h0, addrExt, ready, interrupt_enable,
                    driveFunc[5:1], 1'b0};
                tdc_pkg::ADDR_WC: regRdata <= transfer_word_counter;
                tdc_pkg::ADDR_BA: regRdata <= {memory_bus_address, 1'b0};
                tdc_pkg::ADDR_CS3: regRdata <= {9'h000, interrupt_enable,
                    6'h00};
                tdc_pkg::ADDR_CTRL: regRdata <= {14'h0000, dblMode, 1'b0};
                default: regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ie_sw_only: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        $rose(interrupt_enable) |-> $past(ieWrite))
        else $error("enable set without a write");
    a_ie_clears: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (intAck || busInit || ctlClear) |=> !interrupt_enable)
        else $error("enable not cleared");
    a_sw_int: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (wrCs1 && regWdata[tdc_pkg::IE_BIT] && regWdata[tdc_pkg::RDY_BIT]
        && !busInit && !ctlClear) |=> intReq)
        else $error("no software interrupt");
    a_xfer_busy: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (startXfer && !busInit && !ctlClear) |=> (busy && !ready))
        else $error("transfer did not go busy");
    a_wc_step: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (state == ST_XFER && wordDone
        && !(regWr && regAddr == tdc_pkg::ADDR_WC))
        |=> transfer_word_counter == $past(transfer_word_counter) + 16'h0001)
        else $error("word counter did not step");
    a_ba_bit0: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        ($past(regRd) && $past(regAddr) == tdc_pkg::ADDR_BA)
        |-> regRdata == {$past(memory_bus_address), 1'b0})
        else $error("address read back wrong");
    a_ba_clear: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (busInit || ctlClear)
        |=> memAddr == {tdc_pkg::EXT_RESET, tdc_pkg::BA_RESET})
        else $error("address not cleared");
    a_addr_step: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (state == ST_XFER && wordDone && !busInit && !ctlClear && !reverseDir)
        |=> memAddr == $past(memAddr) + ($past(dblMode)
        ? tdc_pkg::STEP_DOUBLE : tdc_pkg::STEP_SINGLE))
        else $error("bad address step");
    a_stop_zero: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (state == ST_XFER && wordDone && transfer_word_counter == 16'hffff)
        |=> (!wordReq && ready))
        else $error("transfer did not stop");
    a_ie_cancel: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (wrCs1 && !regWdata[tdc_pkg::IE_BIT] && ready && readyQ
        && !drive_attention) |=> !intReq)
        else $error("request not cancelled");
    c_xfer: cover property (@(posedge core_clk) disable iff (!arst_n)
        startXfer ##[1:50] (ready && !busy));
    c_swint: cover property (@(posedge core_clk) disable iff (!arst_n)
        $rose(intReq));
    c_drive_attention: cover property (@(posedge core_clk) disable iff (!arst_n)
        interrupt_enable && drive_attention);
endmodule : tdc_cmd_regs

// >>> tb/tdc_drive_model.sv
// tape formatter model on the drive bus: keeps function codes per unit
// assumes one function write per driveWr pulse; rewinds end with attention
`timescale 1ns/1ps
module tdc_drive_model #(
    parameter int DELAY = 4
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic driveWr,
    input wire logic [2:0] driveUnit,
    input wire logic [5:0] driveFunc,
    input wire logic [2:0] probeUnit,
    output logic [5:0] probeFunc,
    output logic drive_attention
);
    logic [5:0] funcStore [8];
    logic [7:0] cnt;
    // any new command drops attention, as a real drive would
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
            drive_attention <= 1'b0;
        end else if (driveWr) begin
            drive_attention <= 1'b0;
            cnt <= (driveFunc == tdc_pkg::FN_REWIND ||
                    driveFunc == tdc_pkg::FN_REWIND_OFF) ? 8'(DELAY) : 8'h00;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01) begin
                drive_attention <= 1'b1;
            end
        end
    end
    // code lives in the drive, not in the controller
    always_ff @(posedge core_clk) begin
        if (driveWr) begin
            funcStore[driveUnit] <= driveFunc;
        end
    end
    assign probeFunc = funcStore[probeUnit];
endmodule : tdc_drive_model

// >>> tb/tdc_cmd_regs_bench.sv
// bench for the command, counter and address registers
// assumes the drive model on the drive bus; memory side driven here
`timescale 1ns/1ps
module tdc_cmd_regs_bench;
    typedef struct packed {
        logic [2:0] wa;
        logic [15:0] wd;
        logic [2:0] ra;
        logic [15:0] mask;
        logic [15:0] exp;
    } tdc_row_t;
    logic core_clk = 1'b0, arst_n = 1'b0;
    logic [3:0] pulseVec = 4'h0;
    logic [2:0] regAddr = 3'h0, unitSel = 3'h0, probeUnit = 3'h0;
    logic [15:0] regWdata = 16'h0000, regRdata;
    logic regWr = 1'b0, regRd = 1'b0;
    logic driveWr, drive_attention, intReq, wordReq, busy;
    logic [2:0] driveUnit;
    logic [5:0] driveFunc, probeFunc;
    logic [17:0] memAddr;
    int bad_count = 0, cmp_count = 0;
    tdc_row_t rows [9];
    logic [5:0] codes [3];
    always #50 core_clk = ~core_clk;
    tdc_cmd_regs dut_u (.core_clk(core_clk), .arst_n(arst_n),
        .busInit(pulseVec[0]), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .unitSel(unitSel), .driveWr(driveWr), .driveUnit(driveUnit),
        .driveFunc(driveFunc), .drive_attention(drive_attention),
        .intReq(intReq), .intAck(pulseVec[1]), .wordReq(wordReq),
        .wordDone(pulseVec[2]), .xferError(pulseVec[3]),
        .memAddr(memAddr), .busy(busy));
    tdc_drive_model #(.DELAY(4)) drv_u (.core_clk(core_clk),
        .arst_n(arst_n), .driveWr(driveWr), .driveUnit(driveUnit),
        .driveFunc(driveFunc), .probeUnit(probeUnit),
        .probeFunc(probeFunc), .drive_attention(drive_attention));
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    task chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // results of a taken request are sampled 1 ns after the taking edge
    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        #1;
    endtask : wr
    task rdchk(input logic [2:0] a, input logic [15:0] m,
               input logic [15:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk({2'h0, regRdata & m}, {2'h0, e});
    endtask : rdchk
    task pulse(input logic [3:0] v);
        @(posedge core_clk);
        pulseVec <= v;
        @(posedge core_clk);
        pulseVec <= 4'h0;
        #1;
    endtask : pulse
    task xfer(input logic [15:0] ba, input logic [15:0] ctl,
              input logic [15:0] cs, input int n, input logic [17:0] ea);
        wr(tdc_pkg::ADDR_BA, ba);
        wr(tdc_pkg::ADDR_WC, 16'h0000 - 16'(n));
        wr(tdc_pkg::ADDR_CTRL, ctl);
        wr(tdc_pkg::ADDR_CS1, cs);
        chk({17'h0, busy}, 18'h1);
        chk({17'h0, wordReq}, 18'h1);
        wr(tdc_pkg::ADDR_CS1, cs);
        chk({17'h0, driveWr}, 18'h0);
        wr(tdc_pkg::ADDR_CS1, (cs & 16'h0040) | 16'h0001);
        chk({17'h0, driveWr}, 18'h1);
        repeat (n) pulse(4'h4);
        chk({17'h0, wordReq}, 18'h0);
        chk({17'h0, busy}, 18'h0);
        chk(memAddr, ea);
        rdchk(tdc_pkg::ADDR_WC, 16'hffff, 16'h0000);
    endtask : xfer
    initial begin
        #200000;
        bad_count++;
        test_done;
    end
    initial begin
        rows[0] = '{3'h1, 16'h1234, 3'h1, 16'hffff, 16'h1234};
        rows[1] = '{3'h1, 16'h0000, 3'h1, 16'hffff, 16'h0000};
        rows[2] = '{3'h2, 16'h1235, 3'h2, 16'hffff, 16'h1234};
        rows[3] = '{3'h2, 16'hffff, 3'h2, 16'hffff, 16'hfffe};
        rows[4] = '{3'h5, 16'habcd, 3'h5, 16'hffff, 16'h0000};
        rows[5] = '{3'h3, 16'h0040, 3'h0, 16'h0040, 16'h0040};
        rows[6] = '{3'h0, 16'h0000, 3'h3, 16'h0040, 16'h0000};
        rows[7] = '{3'h0, 16'h0040, 3'h3, 16'h0040, 16'h0040};
        rows[8] = '{3'h3, 16'h0000, 3'h0, 16'h0040, 16'h0000};
        codes = '{tdc_pkg::FN_NOP, tdc_pkg::FN_REWIND_OFF, tdc_pkg::FN_REWIND};
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        #1;
        chk({16'h0, busy, intReq}, 18'h0);
        rdchk(tdc_pkg::ADDR_CS1, 16'hffff, 16'h0080);
        rdchk(tdc_pkg::ADDR_BA, 16'hffff, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            wr(rows[i].wa, rows[i].wd);
            rdchk(rows[i].ra, rows[i].mask, rows[i].exp);
        end
        $display("test register rows done");
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            unitSel <= 3'(k + 1);
            wr(tdc_pkg::ADDR_CS1, {10'h000, codes[k]});
            chk({9'h0, driveWr, driveUnit, driveFunc},
                {9'h0, 1'b1, 3'(k + 1), codes[k]});
            chk({17'h0, busy}, 18'h0);
            probeUnit = 3'(k + 1);
            @(posedge core_clk);
            #1;
            chk({12'h0, probeFunc}, {12'h0, codes[k]});
        end
        repeat (8) @(posedge core_clk);
        #1;
        chk({16'h0, drive_attention, intReq}, 18'h2);
        wr(tdc_pkg::ADDR_CS3, 16'h0040);
        chk({17'h0, intReq}, 18'h1);
        pulse(4'h2);
        chk({17'h0, intReq}, 18'h0);
        rdchk(tdc_pkg::ADDR_CS1, 16'h0040, 16'h0000);
        $display("test commands done");
        xfer(16'h1000, 16'h0000, 16'h0071, 3, 18'h01006);
        @(posedge core_clk);
        #1;
        chk({17'h0, intReq}, 18'h1);
        pulse(4'h4);
        chk(memAddr, 18'h01006);
        pulse(4'h2);
        chk({17'h0, intReq}, 18'h0);
        xfer(16'hfffc, 16'h0002, 16'h0031, 1, 18'h10000);
        rdchk(tdc_pkg::ADDR_CS1, 16'h0300, 16'h0100);
        xfer(16'h0100, 16'h0002, 16'h0037, 1, 18'h000fc);
        $display("test transfers done");
        wr(tdc_pkg::ADDR_WC, 16'hfff0);
        wr(tdc_pkg::ADDR_CS1, 16'h0071);
        pulse(4'h8);
        chk({17'h0, busy}, 18'h0);
        @(posedge core_clk);
        #1;
        chk({17'h0, intReq}, 18'h1);
        rdchk(tdc_pkg::ADDR_CS1, 16'h4000, 16'h4000);
        pulse(4'h2);
        $display("test transfer error done");
        wr(tdc_pkg::ADDR_CS1, 16'h00c0);
        chk({17'h0, intReq}, 18'h1);
        wr(tdc_pkg::ADDR_CS1, 16'h0000);
        chk({17'h0, intReq}, 18'h0);
        $display("test soft interrupt done");
        wr(tdc_pkg::ADDR_BA, 16'h2222);
        wr(tdc_pkg::ADDR_WC, 16'h5555);
        pulse(4'h1);
        rdchk(tdc_pkg::ADDR_BA, 16'hffff, 16'h0000);
        rdchk(tdc_pkg::ADDR_WC, 16'hffff, 16'h5555);
        wr(tdc_pkg::ADDR_BA, 16'h2222);
        wr(tdc_pkg::ADDR_CTRL, 16'h0001);
        rdchk(tdc_pkg::ADDR_BA, 16'hffff, 16'h0000);
        rdchk(tdc_pkg::ADDR_WC, 16'hffff, 16'h5555);
        $display("test clears done");
        test_done;
    end
endmodule : tdc_cmd_regs_bench
